// file: hw/sra_pkg.sv
/*
 Types of the serial register-access port.
 Assumes sra_regs.svh is on the include path.
*/
`include "sra_regs.svh"

package sra_pkg;

   // the three link pins, kept together through synchronisation
   typedef struct packed {
      logic cs_n;
      logic sclk;
      logic serial_in;
   } sra_pins_t;

   // synchroniser state: three stages plus the agreed value
   typedef struct packed {
      sra_pins_t s1;
      sra_pins_t s2;
      sra_pins_t s3;
      sra_pins_t q;
   } sra_sync_t;

   typedef logic [`SRA_DEPTH-1:0][`SRA_DATA_W-1:0] sra_mem_t;

   // whole state of the port except the synchroniser
   typedef struct packed {
      logic sclk_d;
      logic [`SRA_CNT_W-1:0] bit_cnt;
      logic hdr_done;
      logic rd;
      logic [`SRA_ADDR_W-1:0] hdr;
      logic [`SRA_ADDR_W-1:0] addr;
      logic [`SRA_DATA_W-1:0] shin;
      logic [`SRA_DATA_W-1:0] shout;
      logic so;
      logic so_en_n;
      logic wr_stb;
      logic [`SRA_ADDR_W-1:0] wr_addr;
      logic [`SRA_DATA_W-1:0] wr_data;
      sra_mem_t mem;
   } sra_state_t;

endpackage

// file: hw/sra_regs.svh
/*
 Offsets, field positions, reset values and counts of the serial
 register-access port, all as macros.
 Assumes it is included by bare name from package and modules alike.
*/
`ifndef SRA_REGS_SVH
`define SRA_REGS_SVH

// address and data widths of one frame
`define SRA_ADDR_W 15
`define SRA_DATA_W 8
`define SRA_CNT_W 5

// header bits before the data byte: flag plus address
`define SRA_HDR_LAST 5'h0_00F
// last bit index of one data byte
`define SRA_BYTE_LAST 5'h0_007

// number of byte registers held in flip-flops
`define SRA_DEPTH 32
`define SRA_IDX_W 5

// first configuration register, stepping direction mirrored twice
`define SRA_CFG_A_ADDR 15'h0_000
`define SRA_CFG_A_RESET 8'h30
`define SRA_STEP_UP_HI 5
`define SRA_STEP_UP_LO 2

// user configuration register, address hold bit
`define SRA_USR_CFG_ADDR 15'h0_010
`define SRA_USR_CFG_RESET 8'h00
`define SRA_HOLD_BIT 3

`endif

// file: hw/sra_slave.sv
/*
 Serial register-access slave: 24-bit frames, streaming with address
 stepping, byte registers held in flip-flops.
 Assumes the host drives chip select, serial clock and serial data in
 from outside the CLK domain. A pin change is acted on about five CLK
 after it happens (three sampling flops, the agreement stage, then the
 state register), so each serial clock phase must last at least four
 CLK. Read bits change about five CLK after the rise that took the
 previous bit and stand until the same point after the next rise: the
 host samples at its rising edge, like every other bit of the frame.
 Addresses 0x000..0x01F are backed by flip-flops; other addresses
 strobe writes out but keep nothing and read back as zero. Stepping
 wraps modulo the address width.
 CE low freezes the synchroniser together with the state, so the host
 must not move the pins while the block is frozen.

*/
`timescale 1ns/100ps
`include "sra_regs.svh"

module sra_slave (
   input wire logic CLK,
   input wire logic SRST,
   input wire logic CE,
   input wire logic CHIP_SELECT_N,
   input wire logic SERIAL_CLK,
   input wire logic SERIAL_IN,
   output logic SERIAL_OUT,
   output logic SERIAL_OUT_EN_N,
   output logic WR_STROBE,
   output logic [`SRA_ADDR_W-1:0] WR_ADDR,
   output logic [`SRA_DATA_W-1:0] WR_DATA,
   output logic ADDR_STEP_UP,
   output logic ADDR_HOLD
);

   // pins before and after the synchroniser, state and its next value
   sra_pkg::sra_pins_t pins_raw;
   sra_pkg::sra_pins_t pins;
   sra_pkg::sra_state_t r;
   sra_pkg::sra_state_t next_r;
   logic rise;
   logic [`SRA_ADDR_W-1:0] hdr_addr;
   logic [`SRA_DATA_W-1:0] in_byte;

   // stepping direction; the low mirror bit is kept by the host only
   function automatic logic step_up(input sra_pkg::sra_mem_t m);
      step_up = m[`SRA_CFG_A_ADDR][`SRA_STEP_UP_HI];
   endfunction

   // address hold flag of the user configuration byte
   function automatic logic addr_hold(input sra_pkg::sra_mem_t m);
      addr_hold = m[`SRA_USR_CFG_ADDR][`SRA_HOLD_BIT];
   endfunction

   // next register address, honouring direction and hold
   function automatic logic [`SRA_ADDR_W-1:0] step_addr(
      input logic [`SRA_ADDR_W-1:0] a,
      input sra_pkg::sra_mem_t m
   );
      logic up;
      logic hold;
      up = step_up(m);
      hold = addr_hold(m);
      if (hold) begin
         step_addr = a;
      end else if (up) begin
         step_addr = a + 15'h0_001;
      end else begin
         step_addr = a - 15'h0_001;
      end
   endfunction

   // true when the address falls inside the flip-flop storage
   function automatic logic in_range(input logic [`SRA_ADDR_W-1:0] a);
      in_range = (a < 15'(`SRA_DEPTH));
   endfunction

   // byte at an address; unbacked addresses read as zero
   function automatic logic [`SRA_DATA_W-1:0] read_byte(
      input logic [`SRA_ADDR_W-1:0] a,
      input sra_pkg::sra_mem_t m
   );
      if (in_range(a)) begin
         read_byte = m[a[`SRA_IDX_W-1:0]];
      end else begin
         read_byte = 8'h00;
      end
   endfunction

   // fresh output byte with its msb already split off for the pin
   function automatic logic [`SRA_DATA_W:0] load_out(
      input logic [`SRA_ADDR_W-1:0] a,
      input sra_pkg::sra_mem_t m
   );
      logic [`SRA_DATA_W-1:0] b;
      b = read_byte(a, m);
      load_out = {b[`SRA_DATA_W-1], b};
   endfunction

   // raw pins gathered into one group for the synchroniser
   assign pins_raw.cs_n = CHIP_SELECT_N;
   assign pins_raw.sclk = SERIAL_CLK;
   assign pins_raw.serial_in = SERIAL_IN;

   // all three pins cross from the host's domain together
   sra_sync3 u_sync (
      .clk(CLK),
      .srst(SRST),
      .ce(CE),
      .d(pins_raw),
      .q(pins)
   );

   // rise of the agreed serial clock; no edge means no change.
   // sclk_d follows while deselected too, so a select that falls
   // with the clock high still waits for a fresh rise
   assign rise = pins.sclk & ~r.sclk_d;

   // header with the newest bit appended, msb first
   assign hdr_addr = {r.hdr[`SRA_ADDR_W-2:0], pins.serial_in};
   assign in_byte = {r.shin[`SRA_DATA_W-2:0], pins.serial_in};

   // frame sequencing
   always_comb begin
      next_r = r;
      next_r.wr_stb = 1'b0;
      next_r.sclk_d = pins.sclk;
      if (pins.cs_n) begin
         // deselect drops any partial frame or byte
         next_r.bit_cnt = '0;
         next_r.hdr_done = 1'b0;
         next_r.so_en_n = 1'b1;
         next_r.so = 1'b0;
      end else if (rise && !r.hdr_done) begin
         // header phase: flag then address
         next_r.hdr = hdr_addr;
         next_r.bit_cnt = r.bit_cnt + 5'h0_001;
         if (r.bit_cnt == `SRA_HDR_LAST) begin
            next_r.hdr_done = 1'b1;
            next_r.rd = r.hdr[`SRA_ADDR_W-1];
            next_r.addr = hdr_addr;
            next_r.bit_cnt = '0;
            if (r.hdr[`SRA_ADDR_W-1]) begin
               // first read bit must be out before the next rise
               {next_r.so, next_r.shout} = load_out(hdr_addr, r.mem);
               next_r.so_en_n = 1'b0;
            end
         end
      end else if (rise) begin
         // data phase: input is collected but only writes use it
         next_r.shin = in_byte;
         next_r.bit_cnt = r.bit_cnt + 5'h0_001;
         if (r.rd) begin
            // next read bit leaves just after the rise that took this one,
            // so it has settled long before the host samples it
            next_r.shout = {r.shout[`SRA_DATA_W-2:0], 1'b0};
            next_r.so = r.shout[`SRA_DATA_W-2];
         end
         if (r.bit_cnt == `SRA_BYTE_LAST) begin
            next_r.bit_cnt = '0;
            next_r.addr = step_addr(r.addr, r.mem);
            if (!r.rd) begin
               // store and strobe one byte; unbacked addresses only strobe
               if (in_range(r.addr)) begin
                  next_r.mem[r.addr[`SRA_IDX_W-1:0]] = in_byte;
               end
               next_r.wr_stb = 1'b1;
               next_r.wr_addr = r.addr;
               next_r.wr_data = in_byte;
            end else begin
               // streaming read: next byte follows at once
               {next_r.so, next_r.shout} = load_out(next_r.addr, r.mem);
            end
         end
      end
   end

   // state register; configuration bytes take their reset values
   // reset ignores CE, so a frozen block can still be cleared
   always_ff @(posedge CLK) begin
      if (SRST) begin
         r <= '0;
         r.so_en_n <= 1'b1;
         r.mem[`SRA_CFG_A_ADDR] <= `SRA_CFG_A_RESET;
         r.mem[`SRA_USR_CFG_ADDR] <= `SRA_USR_CFG_RESET;
      end else if (CE) begin
         r <= next_r;
      end
   end

   // every output straight from the state register
   assign SERIAL_OUT = r.so;
   assign SERIAL_OUT_EN_N = r.so_en_n;
   assign WR_STROBE = r.wr_stb;
   assign WR_ADDR = r.wr_addr;
   assign WR_DATA = r.wr_data;
   assign ADDR_STEP_UP = step_up(r.mem);
   assign ADDR_HOLD = addr_hold(r.mem);

endmodule

// file: hw/sra_sync3.sv
/*
 Three-stage synchroniser for the link pins with agreement filter.
 Assumes the pins are asynchronous to CLK; output follows once the
 second and third stages agree.
*/
`timescale 1ns/100ps

module sra_sync3 (
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   input wire sra_pkg::sra_pins_t d,
   output sra_pkg::sra_pins_t q
);

   sra_pkg::sra_sync_t r;
   sra_pkg::sra_sync_t next_r;

   // stage one feeds only stage two; filter looks at two and three
   always_comb begin
      next_r = r;
      next_r.s1 = d;
      next_r.s2 = r.s1;
      next_r.s3 = r.s2;
      if (r.s2 == r.s3) begin
         next_r.q = r.s3;
      end
   end

   // idle link: chip select high, clock and data low
   always_ff @(posedge clk) begin
      if (srst) begin
         r <= '0;
         r.s1.cs_n <= 1'b1;
         r.s2.cs_n <= 1'b1;
         r.s3.cs_n <= 1'b1;
         r.q.cs_n <= 1'b1;
      end else if (ce) begin
         r <= next_r;
      end
   end

   assign q = r.q;

endmodule

// file: testbench/sra_host.sv
/* host model: drives the link, gathers read bytes.
   assumes the slave takes data on serial clock rise and moves read
   data just after it; pins change 2 ns after a CLK rise. */
`timescale 1ns/100ps
module sra_host (
   input wire logic clk,
   output logic cs_n,
   output logic sck,
   output logic serial_in,
   input wire logic serial_out,
   input wire logic sdo_en_n
);
   logic [7:0] rd_byte;
   int stall_at = -1;
   event got;
   // idle: deselected, clock parked, no calibration modelled
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      serial_in = 1'b0;
   end
   // pins move a fixed 2 ns after a CLK rise, like all bench stimulus
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   // one select period, msb first, clock runs only inside it
   task automatic xfer(input logic [47:0] v, input int n);
      int k;
      k = 0;
      tick(1);
      cs_n = 1'b0;
      for (int i = 0; i < n; i++) begin
         serial_in = v[47-i];
         if (i == stall_at) tick(100);
         tick(4);
         sck = 1'b1;
         // sample at the rise; the device moved this bit after the last
         if (sdo_en_n === 1'b0) begin
            rd_byte = {rd_byte[6:0], serial_out};
            k++;
            if (k % 8 == 0) -> got;
         end
         tick(4);
         sck = 1'b0;
      end
      serial_in = ~serial_in; // released line keeps no level
      tick(4);
      cs_n = 1'b1;
      tick(10);
   endtask
endmodule

// file: testbench/sra_slave_checker.sv
/* port assertions for the serial register-access slave.
   assumes a bind onto sra_slave, one clock domain. */
`timescale 1ns/100ps
module sra_slave_checker (
   input wire logic CLK,
   input wire logic SRST,
   input wire logic CHIP_SELECT_N,
   input wire logic SERIAL_CLK,
   input wire logic SERIAL_OUT,
   input wire logic SERIAL_OUT_EN_N,
   input wire logic WR_STROBE,
   input wire logic [14:0] WR_ADDR,
   input wire logic [7:0] WR_DATA,
   input wire logic ADDR_STEP_UP,
   input wire logic ADDR_HOLD
);
   default clocking @(posedge CLK); endclocking
   default disable iff (SRST);
   // eight cycles outlast the pin pipeline plus output register
   sequence idle8;
      CHIP_SELECT_N [*8];
   endsequence
   sequence quiet8;
      !WR_STROBE [*8];
   endsequence
   a_idle_released: assert property (idle8 |-> SERIAL_OUT_EN_N)
      else $error("output driven while deselected");
   a_idle_no_write: assert property (idle8 |-> !WR_STROBE)
      else $error("write while deselected");
   a_out_low_off: assert property (SERIAL_OUT_EN_N |-> !SERIAL_OUT)
      else $error("data bit while released");
   a_still_clock: assert property (
      (!CHIP_SELECT_N && $stable(SERIAL_CLK)) [*8] |-> $stable(SERIAL_OUT))
      else $error("output moved with clock stopped");
   a_strobe_pulse: assert property (WR_STROBE |=> !WR_STROBE)
      else $error("strobe too long");
   a_write_holds: assert property (
      !WR_STROBE |-> $stable(WR_ADDR) && $stable(WR_DATA))
      else $error("write fields moved without strobe");
   a_read_quiet: assert property (
      $fell(SERIAL_OUT_EN_N) |-> !CHIP_SELECT_N ##0 quiet8)
      else $error("read drive without select or with a write");
   a_reset_values: assert property (
      $fell(SRST) |-> ADDR_STEP_UP && !ADDR_HOLD && SERIAL_OUT_EN_N)
      else $error("wrong level after reset");
endmodule
bind sra_slave sra_slave_checker u_chk (.CLK(CLK), .SRST(SRST),
   .CHIP_SELECT_N(CHIP_SELECT_N), .SERIAL_CLK(SERIAL_CLK),
   .SERIAL_OUT(SERIAL_OUT), .SERIAL_OUT_EN_N(SERIAL_OUT_EN_N),
   .WR_STROBE(WR_STROBE), .WR_ADDR(WR_ADDR), .WR_DATA(WR_DATA),
   .ADDR_STEP_UP(ADDR_STEP_UP), .ADDR_HOLD(ADDR_HOLD));

// file: testbench/sra_slave_test.sv
/* bench for the serial register-access slave: host model drives the
   link, a monitor checks writes and read bytes against notes. */
`timescale 1ns/100ps
`include "sra_regs.svh"
module sra_slave_test;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic cs_n, sck, serial_in, so, so_en_n, wr_stb, up, hold;
   logic [14:0] wr_addr;
   logic [7:0] wr_data;
   logic [7:0] mem [32];
   logic [22:0] wq [$];
   logic [7:0] rq [$];
   int miscompares = 0;
   int cmp_count = 0;
   // 50 MHz system clock
   initial begin
      forever #10 clk = ~clk;
   end
   sra_slave u_dut (.CLK(clk), .SRST(srst), .CE(1'b1),
      .CHIP_SELECT_N(cs_n), .SERIAL_CLK(sck), .SERIAL_IN(serial_in),
      .SERIAL_OUT(so), .SERIAL_OUT_EN_N(so_en_n), .WR_STROBE(wr_stb),
      .WR_ADDR(wr_addr), .WR_DATA(wr_data), .ADDR_STEP_UP(up),
      .ADDR_HOLD(hold));
   sra_host u_host (.clk(clk), .cs_n(cs_n), .sck(sck), .serial_in(serial_in),
      .serial_out(so), .sdo_en_n(so_en_n));
   task automatic chk_wr(input logic [22:0] e, input logic [22:0] s);
      cmp_count++;
      if (s !== e) begin
         miscompares++;
         $display("ERROR write expected %h seen %h", e, s);
      end
   endtask
   task automatic chk_byte(input string nm, input logic [7:0] e,
                           input logic [7:0] s);
      cmp_count++;
      if (s !== e) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask
   // monitors: oldest note against each result as it shows
   always @(negedge clk) begin
      if (wr_stb === 1'b1) begin
         chk_wr(wq.size() ? wq.pop_front() : 'x, {wr_addr, wr_data});
      end
   end
   always @(u_host.got) begin
      chk_byte("read", rq.size() ? rq.pop_front() : 'x, u_host.rd_byte);
   end
   task automatic rst();
      @(posedge clk);
      #2 srst = 1'b1;
      repeat (10) @(posedge clk);
      #2 srst = 1'b0;
      mem = '{default: 8'h00};
      mem[0] = `SRA_CFG_A_RESET;
      repeat (6) @(posedge clk);
   endtask
   // one access of nb bytes, stepping st per byte; notes go first
   task automatic op(input logic r, input logic [14:0] a,
                     input logic [23:0] d, input int nb, input int st);
      logic [14:0] x;
      for (int j = 0; j < nb; j++) begin
         x = a + 15'(j * st);
         if (r) rq.push_back(mem[x]);
         else wq.push_back({x, d[23-8*j -: 8]});
         if (!r) mem[x] = d[23-8*j -: 8];
      end
      u_host.xfer({r, a, d, 8'h00}, 16 + 8 * nb);
   endtask
   task automatic conclude();
      chk_byte("left", 8'h00, 8'(wq.size() + rq.size()));
      if (miscompares == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // watchdog on the whole run
   initial begin
      #1000000 miscompares++;
      conclude();
   end
   initial begin
      void'($urandom(76));
      rst();
      op(1'b0, 15'h0_001, 24'($urandom), 1, 1);
      op(1'b1, 15'h0_001, 24'($urandom), 1, 1);
      op(1'b0, 15'h0_002, 24'($urandom), 3, 1);
      u_host.stall_at = 19;
      op(1'b1, 15'h0_002, 24'($urandom), 3, 1);
      u_host.stall_at = -1;
      u_host.xfer({1'b0, 15'h0_005, 32'hFFFF_FFFF}, 23);
      op(1'b1, 15'h0_005, 24'h00_0000, 1, 1);
      op(1'b0, 15'h0_000, 24'h00_0000, 1, 1);
      chk_byte("step up", 8'h00, {7'h00, up});
      op(1'b0, 15'h0_008, 24'($urandom), 2, -1);
      op(1'b0, `SRA_USR_CFG_ADDR, 24'h08_0000, 1, -1);
      chk_byte("hold", 8'h01, {7'h00, hold});
      op(1'b0, 15'h0_009, 24'($urandom), 2, 0);
      op(1'b1, 15'h0_009, 24'h00_0000, 2, 0);
      rst();
      chk_byte("step up", 8'h01, {7'h00, up});
      op(1'b1, 15'h0_000, 24'h00_0000, 2, 1);
      conclude();
   end
endmodule
